// ---- hdl/pmrs_regs.vh ----
// Purpose: constants for the port multiplier reset and signature block
// Assumes: AXI4-Lite byte addresses, 32-bit data
// Notes:   offsets chosen for this block
`ifndef PMRS_REGS_VH
`define PMRS_REGS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define PMRS_OFF_CTRL      8'h00
`define PMRS_OFF_STATUS    8'h04
`define PMRS_OFF_PORTEN    8'h08
`define PMRS_OFF_SIG0      8'h0C
`define PMRS_OFF_SIG1      8'h10
`define PMRS_OFF_SIG2      8'h14
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define PMRS_CTRL_AWARE    0
`define PMRS_CTRL_COMINIT  1
`define PMRS_PORTEN_RST    16'h0000
`define PMRS_PORT0_ONLY    16'h0001
`define PMRS_STAT_RDY      8'h40
`define PMRS_ZERO8         8'h00
// ----------------------------------------
// timing and response codes
// ----------------------------------------
`define PMRS_CLEAR_CYCLES  8'h10
`define PMRS_RESP_OKAY     2'b00
`define PMRS_RESP_SLVERR   2'b10
`endif

// ---- hdl/pmrs_core.v ----
// Purpose: reset sequencing and control-port signature response of a port multiplier
// Assumes: received frames arrive as one-cycle strobes from link logic on aclk;
//          link reset and cominit-sent arrive from the phy domain (synchronised here)
//          NPORTS is at most 16, the width of the enable register
// Notes:   software reaches control and status over AXI4-Lite
//          signature bytes are parameters; their defaults are arbitrary
//          only aresetn and a received link reset clear the block
`timescale 1ns/10ps
`include "pmrs_regs.vh"
module pmrs_core #(
  parameter [7:0] SIG_SECCNT = 8'hA5,  // arbitrary value
  parameter [7:0] SIG_LBA_LO = 8'h5A,  // arbitrary value
  parameter [7:0] SIG_LBA_MD = 8'hC3,  // arbitrary value
  parameter [7:0] SIG_LBA_HI = 8'h3C,  // arbitrary value
  parameter       NPORTS     = 15
) (
  input  wire               aclk,
  input  wire               aresetn,
  input  wire               link_reset_in,
  input  wire               cominit_sent_in,
  input  wire               rx_reg_fis_stb,
  input  wire               rx_ctrl_port,
  input  wire               rx_srst,
  input  wire               rx_is_cmd,
  input  wire [7:0]         rx_command,
  output reg                tx_sig_valid,
  input  wire               tx_sig_ready,
  output reg  [7:0]         tx_status,
  output reg  [7:0]         tx_error,
  output reg  [7:0]         tx_device,
  output reg  [7:0]         tx_seccnt,
  output reg  [7:0]         tx_seccnt_exp,
  output reg  [7:0]         tx_lba_lo,
  output reg  [7:0]         tx_lba_lo_exp,
  output reg  [7:0]         tx_lba_md,
  output reg  [7:0]         tx_lba_md_exp,
  output reg  [7:0]         tx_lba_hi,
  output reg  [7:0]         tx_lba_hi_exp,
  output reg                unsup_cmd_stb,
  output reg                clear_stb,
  output reg                ready_q,
  output reg  [NPORTS-1:0]  port_en,
  input  wire [7:0]         s_axi_awaddr,
  input  wire               s_axi_awvalid,
  output reg                s_axi_awready,
  input  wire [31:0]        s_axi_wdata,
  input  wire [3:0]         s_axi_wstrb,
  input  wire               s_axi_wvalid,
  output reg                s_axi_wready,
  output reg  [1:0]         s_axi_bresp,
  output reg                s_axi_bvalid,
  input  wire               s_axi_bready,
  input  wire [7:0]         s_axi_araddr,
  input  wire               s_axi_arvalid,
  output reg                s_axi_arready,
  output reg  [31:0]        s_axi_rdata,
  output reg  [1:0]         s_axi_rresp,
  output reg                s_axi_rvalid,
  input  wire               s_axi_rready
);

  localparam [7:0] CMD_DEV_RESET = 8'h08;
  localparam [1:0] ST_NOCOMM = 2'b00;
  localparam [1:0] ST_CLEAR  = 2'b01;
  localparam [1:0] ST_RUN    = 2'b10;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // third flop only delays stage two for the edge detect
  reg        lr_s1_q, lr_s2_q, lr_s3_q;
  reg        ci_s1_q, ci_s2_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      lr_s1_q <= 1'b0;
      lr_s2_q <= 1'b0;
      lr_s3_q <= 1'b0;
      ci_s1_q <= 1'b0;
      ci_s2_q <= 1'b0;
    end else begin
      lr_s1_q <= link_reset_in;
      lr_s2_q <= lr_s1_q;
      lr_s3_q <= lr_s2_q;
      ci_s1_q <= cominit_sent_in;
      ci_s2_q <= ci_s1_q;
    end
  end
  // a level held through a clear fires once only
  wire link_reset_rise = lr_s2_q & ~lr_s3_q;

  // ----------------------------------------
  // host-port reset sequencer
  // ----------------------------------------
  reg [1:0] state_q;
  reg [7:0] clr_cnt_q;
  reg       cominit_done_q;
  reg       aware_q;
  reg       srst_pend_q;
  reg [15:0] port_en_sw_q;

  function [15:0] port_mask;
    input aware;
    input [15:0] sw;
    begin
      // unaware software sees only the drive on port zero
      port_mask = aware ? sw : `PMRS_PORT0_ONLY;
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q        <= ST_NOCOMM;
      clr_cnt_q      <= 8'h00;
      cominit_done_q <= 1'b0;
      clear_stb      <= 1'b0;
      ready_q        <= 1'b0;
    end else begin
      clear_stb <= 1'b0;
      if (ci_s2_q)
        cominit_done_q <= 1'b1;
      // link reset preempts power-up at any step, even before first cominit
      if (link_reset_rise) begin
        state_q        <= ST_NOCOMM;
        cominit_done_q <= 1'b0;
        ready_q        <= 1'b0;
      end else begin
        case (state_q)
          ST_NOCOMM: begin
            // one pulse per entry into the no-communication state
            clear_stb <= 1'b1;
            clr_cnt_q <= `PMRS_CLEAR_CYCLES;
            state_q   <= ST_CLEAR;
          end
          ST_CLEAR: begin
            if (clr_cnt_q == 8'h01) begin
              state_q <= ST_RUN;
              ready_q <= 1'b1;
            end
            clr_cnt_q <= clr_cnt_q - 8'h01;
          end
          ST_RUN: ;
          default: state_q <= ST_NOCOMM;
        endcase
      end
    end
  end

  // frame logic and registers stay in reset for the whole clear
  wire clearing = (state_q != ST_RUN) | link_reset_rise;

  // ----------------------------------------
  // software reset and signature frame
  // ----------------------------------------
  // frames that arrive while clearing are dropped, not queued
  wire ctrl_fis = rx_reg_fis_stb & rx_ctrl_port & (state_q == ST_RUN);
  // a command frame is never a software-reset step
  wire dev_reset_fis = ctrl_fis & rx_is_cmd & (rx_command == CMD_DEV_RESET);
  wire srst_set_fis  = ctrl_fis & ~rx_is_cmd & rx_srst;
  wire srst_clr_fis  = ctrl_fis & ~rx_is_cmd & ~rx_srst;

  always @(posedge aclk) begin
    if (!aresetn || clearing) begin
      srst_pend_q   <= 1'b0;
      tx_sig_valid  <= 1'b0;
      unsup_cmd_stb <= 1'b0;
      tx_status     <= `PMRS_ZERO8;
      tx_error      <= `PMRS_ZERO8;
      tx_device     <= `PMRS_ZERO8;
      tx_seccnt     <= `PMRS_ZERO8;
      tx_seccnt_exp <= `PMRS_ZERO8;
      tx_lba_lo     <= `PMRS_ZERO8;
      tx_lba_lo_exp <= `PMRS_ZERO8;
      tx_lba_md     <= `PMRS_ZERO8;
      tx_lba_md_exp <= `PMRS_ZERO8;
      tx_lba_hi     <= `PMRS_ZERO8;
      tx_lba_hi_exp <= `PMRS_ZERO8;
    end else begin
      unsup_cmd_stb <= 1'b0;
      if (tx_sig_valid && tx_sig_ready)
        tx_sig_valid <= 1'b0;
      if (dev_reset_fis) begin
        unsup_cmd_stb <= 1'b1;
      end else if (srst_set_fis) begin
        srst_pend_q <= 1'b1;
        // a cleared frame meeting an unsent signature leaves the request pending
      end else if (srst_clr_fis && srst_pend_q && !tx_sig_valid) begin
        // only action of a software reset: no state is cleared
        srst_pend_q   <= 1'b0;
        tx_sig_valid  <= 1'b1;
        tx_seccnt     <= SIG_SECCNT;
        tx_lba_lo     <= SIG_LBA_LO;
        tx_lba_md     <= SIG_LBA_MD;
        tx_lba_hi     <= SIG_LBA_HI;
        tx_error      <= `PMRS_ZERO8;
        tx_device     <= `PMRS_ZERO8;
        tx_seccnt_exp <= `PMRS_ZERO8;
        tx_lba_lo_exp <= `PMRS_ZERO8;
        tx_lba_md_exp <= `PMRS_ZERO8;
        tx_lba_hi_exp <= `PMRS_ZERO8;
        tx_status     <= `PMRS_STAT_RDY;
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  reg        aw_hit_q, w_hit_q;
  reg [7:0]  awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;

  // offsets that answer okay; any other draws a slave error
  function known_off;
    input [7:0] addr;
    begin
      case (addr)
        `PMRS_OFF_CTRL, `PMRS_OFF_STATUS, `PMRS_OFF_PORTEN,
        `PMRS_OFF_SIG0, `PMRS_OFF_SIG1, `PMRS_OFF_SIG2: known_off = 1'b1;
        default: known_off = 1'b0;
      endcase
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PMRS_RESP_OKAY;
      aw_hit_q      <= 1'b0;
      w_hit_q       <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
      aware_q       <= 1'b0;
      port_en_sw_q  <= `PMRS_PORTEN_RST;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      // address and data in either order; the response waits for both
      if (s_axi_awvalid && !aw_hit_q && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        aw_hit_q      <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hit_q && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
        w_hit_q      <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
      end
      if (aw_hit_q && w_hit_q && !s_axi_bvalid) begin
        aw_hit_q     <= 1'b0;
        w_hit_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `PMRS_RESP_OKAY;
        if (awaddr_q == `PMRS_OFF_CTRL) begin
          if (wstrb_q[0])
            aware_q <= wdata_q[`PMRS_CTRL_AWARE];
        end else if (awaddr_q == `PMRS_OFF_PORTEN) begin
          if (wstrb_q[0])
            port_en_sw_q[7:0] <= wdata_q[7:0];
          if (wstrb_q[1])
            port_en_sw_q[15:8] <= wdata_q[15:8];
        end else if (!known_off(awaddr_q)) begin
          s_axi_bresp <= `PMRS_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // registers take reset values on every clear; soft reset never reaches here
      if (clearing) begin
        aware_q      <= 1'b0;
        port_en_sw_q <= `PMRS_PORTEN_RST;
      end
    end
  end

  // ----------------------------------------
  // device port enables
  // ----------------------------------------
  wire [15:0] port_mask_w = port_mask(aware_q, port_en_sw_q);

  // with aware set, a write to the enables shows on the ports one cycle later; unaware, port zero alone
  always @(posedge aclk) begin
    if (!aresetn || clearing) begin
      port_en <= {NPORTS{1'b0}};
    end else begin
      port_en <= port_mask_w[NPORTS-1:0];
    end
  end

  // ----------------------------------------
  // status word
  // ----------------------------------------
  wire [31:0] status_w = {{26{1'b0}}, srst_pend_q, tx_sig_valid, cominit_done_q, ready_q, state_q};

  // one read at a time: a new address waits until rvalid is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `PMRS_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= known_off(s_axi_araddr) ? `PMRS_RESP_OKAY : `PMRS_RESP_SLVERR;
        case (s_axi_araddr)
          `PMRS_OFF_CTRL:   s_axi_rdata <= {{31{1'b0}}, aware_q};
          `PMRS_OFF_STATUS: s_axi_rdata <= status_w;
          `PMRS_OFF_PORTEN: s_axi_rdata <= {16'h0000, port_en_sw_q};
          `PMRS_OFF_SIG0:   s_axi_rdata <= {SIG_LBA_HI, SIG_LBA_MD, SIG_LBA_LO, SIG_SECCNT};
          `PMRS_OFF_SIG1:   s_axi_rdata <= {16'h0000, `PMRS_STAT_RDY, `PMRS_ZERO8};
          `PMRS_OFF_SIG2:   s_axi_rdata <= 32'h00000000;
          default:          s_axi_rdata <= 32'h00000000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // pmrs_core

// ---- verification/pmrs_core_asserts.sv ----
// Purpose: port checks for pmrs_core
// Assumes: one clock domain, aresetn low resets
// Notes:   bound to every pmrs_core instance
`timescale 1ns/10ps
module pmrs_core_asserts #(parameter NPORTS = 15) (
  input wire              aclk,
  input wire              aresetn,
  input wire              link_reset_in,
  input wire              rx_reg_fis_stb,
  input wire              rx_ctrl_port,
  input wire              rx_srst,
  input wire              rx_is_cmd,
  input wire [7:0]        rx_command,
  input wire              tx_sig_valid,
  input wire              tx_sig_ready,
  input wire [7:0]        tx_status,
  input wire [7:0]        tx_error,
  input wire [7:0]        tx_device,
  input wire [7:0]        tx_seccnt,
  input wire [7:0]        tx_seccnt_exp,
  input wire [7:0]        tx_lba_lo_exp,
  input wire [7:0]        tx_lba_md_exp,
  input wire [7:0]        tx_lba_hi_exp,
  input wire              unsup_cmd_stb,
  input wire              clear_stb,
  input wire              ready_q,
  input wire [NPORTS-1:0] port_en
);
  wire ctl = rx_reg_fis_stb && rx_ctrl_port && ready_q;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_clear_run;
    ##1 (!ready_q && port_en == '0) [*8] ##[7:9] ready_q;
  endsequence
  // a link reset during the clear restarts it, so that attempt is dropped
  a_clear_run: assert property (disable iff (!aresetn || link_reset_in) clear_stb |-> s_clear_run)
    else $error("clear sequence wrong");
  a_link_reset: assert property ($rose(link_reset_in) |-> ##[2:4] clear_stb)
    else $error("link reset did not clear");
  a_sig_fixed: assert property (tx_sig_valid |-> tx_status == 8'h40 && tx_error == 8'h00 && tx_device == 8'h00)
    else $error("signature fixed fields wrong");
  a_sig_exp_zero: assert property (tx_sig_valid |-> (tx_seccnt_exp | tx_lba_lo_exp | tx_lba_md_exp | tx_lba_hi_exp) == 8'h00)
    else $error("expanded fields not zero");
  a_sig_hold: assert property (tx_sig_valid && !tx_sig_ready |=> tx_sig_valid && $stable(tx_seccnt))
    else $error("signature dropped early");
  a_sig_cause: assert property ($rose(tx_sig_valid) |-> $past(ctl && !rx_srst && !rx_is_cmd))
    else $error("signature without cleared frame");
  a_srst_wait: assert property (ctl && rx_srst |=> !$rose(tx_sig_valid))
    else $error("signature on set frame");
  a_dev_reset: assert property (ctl && rx_is_cmd && rx_command == 8'h08 |=> unsup_cmd_stb)
    else $error("device reset not rejected");
  a_no_self_rst: assert property (ctl |=> !clear_stb && ready_q)
    else $error("frame reset the block");
endmodule // pmrs_core_asserts

bind pmrs_core pmrs_core_asserts #(.NPORTS(NPORTS)) chk_u (.*);

// ---- verification/pmrs_host_model.sv ----
// Purpose: host controller on the host port
// Assumes: frames are one-cycle strobes on aclk
// Notes:   stall sets how late the signature is taken
`timescale 1ns/10ps
module pmrs_host_model (
  input  wire       aclk,
  output reg        link_reset_in,
  output reg        cominit_sent_in,
  output reg        rx_reg_fis_stb,
  output reg        rx_ctrl_port,
  output reg        rx_srst,
  output reg        rx_is_cmd,
  output reg  [7:0] rx_command,
  input  wire       tx_sig_valid,
  output reg        tx_sig_ready,
  input  wire [7:0] tx_device,
  input  wire [7:0] tx_seccnt,
  input  wire [7:0] tx_lba_lo,
  input  wire [7:0] tx_lba_md,
  input  wire [7:0] tx_lba_hi,
  input  wire       unsup_cmd_stb
);
  reg [39:0] sig_q = 40'h0;
  reg [7:0]  sig_cnt = 8'h00, unsup_cnt = 8'h00, wait_q = 8'h00, stall = 8'h00;
  initial begin
    {link_reset_in, cominit_sent_in, rx_reg_fis_stb, rx_ctrl_port} = 4'h0;
    {rx_srst, rx_is_cmd, tx_sig_ready} = 3'h0;
    rx_command = 8'h00;
  end
  always @(posedge aclk) begin
    if (tx_sig_valid && tx_sig_ready) begin
      sig_q <= {tx_device, tx_lba_hi, tx_lba_md, tx_lba_lo, tx_seccnt};
      sig_cnt <= sig_cnt + 8'h01;
      tx_sig_ready <= 1'b0;
      wait_q <= 8'h00;
    end else if (tx_sig_valid) begin
      wait_q <= wait_q + 8'h01;
      tx_sig_ready <= (wait_q >= stall);
    end
    if (unsup_cmd_stb) begin
      unsup_cnt <= unsup_cnt + 8'h01;
    end
  end
  task send(input ctl, input srst, input cmd, input [7:0] code);
    @(posedge aclk);
    rx_reg_fis_stb <= 1'b1;
    {rx_ctrl_port, rx_srst, rx_is_cmd, rx_command} <= {ctl, srst, cmd, code};
    @(posedge aclk);
    rx_reg_fis_stb <= 1'b0;
    // idle fields except rx_is_cmd flip so stale values cannot pass
    {rx_ctrl_port, rx_srst, rx_command} <= {~ctl, ~srst, ~code};
  endtask
  task cominit_up;
    @(posedge aclk);
    cominit_sent_in <= 1'b1;
  endtask
  task comreset;
    @(posedge aclk);
    link_reset_in <= 1'b1;
    repeat (4) @(posedge aclk);
    link_reset_in <= 1'b0;
  endtask
endmodule // pmrs_host_model

// ---- verification/testbench.sv ----
// Purpose: self-checking bench for pmrs_core
// Assumes: AXI4-Lite master in tasks, host model on frames
// Notes:   signature values are bench parameters
`timescale 1ns/10ps
`include "pmrs_regs.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  localparam [31:0] SIG = 32'h3E2D1C0B;  // arbitrary value
  reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg  [7:0]  s_axi_awaddr, s_axi_araddr;
  reg  [31:0] s_axi_wdata, rd;
  reg  [3:0]  s_axi_wstrb;
  reg  [1:0]  rs;
  wire        link_reset_in, cominit_sent_in, rx_reg_fis_stb, rx_ctrl_port, rx_srst, rx_is_cmd, tx_sig_ready;
  wire [7:0]  rx_command, tx_status, tx_error, tx_device, tx_seccnt, tx_seccnt_exp, tx_lba_lo, tx_lba_lo_exp;
  wire [7:0]  tx_lba_md, tx_lba_md_exp, tx_lba_hi, tx_lba_hi_exp;
  wire        tx_sig_valid, unsup_cmd_stb, clear_stb, ready_q, s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire        s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [14:0] port_en;
  integer     err_count, checks_done;
  pmrs_core #(.SIG_SECCNT(SIG[7:0]), .SIG_LBA_LO(SIG[15:8]), .SIG_LBA_MD(SIG[23:16]),
              .SIG_LBA_HI(SIG[31:24])) dut_u (.*);
  pmrs_host_model host_u (.*);
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task finish_test;
    $display("checks_done %0d err_count %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rdw(input [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    {rd, rs} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  task rdchk(input [7:0] a, input [31:0] e);
    rdw(a);
    `CHK(rs, `PMRS_RESP_OKAY)
    `CHK(rd, e)
  endtask
  // both waits matter: ready_q stays up until the clear starts
  task settle;
    do @(posedge aclk); while (!clear_stb);
    do @(posedge aclk); while (!ready_q);
    // port enables follow ready_q by one cycle
    @(posedge aclk);
  endtask
  initial begin
    #200000;
    err_count++;
    finish_test();
  end
  initial begin
    err_count = 0;
    checks_done = 0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    host_u.comreset();
    settle();
    rdchk(`PMRS_OFF_STATUS, 32'h6);
    `CHK(port_en, 15'h0001)
    rdchk(`PMRS_OFF_CTRL, 32'h0);
    rdchk(`PMRS_OFF_PORTEN, 32'h0);
    wr(8'h40, 32'h1);
    `CHK(rs, `PMRS_RESP_SLVERR)
    rdw(8'h40);
    `CHK(rs, `PMRS_RESP_SLVERR)
    wr(`PMRS_OFF_PORTEN, 32'h00F0);
    wr(`PMRS_OFF_CTRL, 32'h1);
    `CHK(rs, `PMRS_RESP_OKAY)
    @(posedge aclk);
    `CHK(port_en, 15'h00F0)
    host_u.cominit_up();
    // prompt host first, then one that stalls
    for (int i = 0; i < 2; i++) begin
      host_u.stall = 8'(i * 5);
      host_u.send(1, 1, 0, 8'h00);
      repeat (4) @(posedge aclk);
      `CHK(host_u.sig_cnt, 8'(i))
      host_u.send(1, 0, 0, 8'h00);
      repeat (12) @(posedge aclk);
      `CHK(host_u.sig_cnt, 8'(i + 1))
      `CHK(host_u.sig_q, {8'h00, SIG})
    end
    `CHK(port_en, 15'h00F0)
    rdchk(`PMRS_OFF_CTRL, 32'h1);
    rdchk(`PMRS_OFF_SIG0, SIG);
    rdchk(`PMRS_OFF_SIG1, 32'h4000);
    rdchk(`PMRS_OFF_SIG2, 32'h0);
    host_u.send(1, 0, 0, 8'h00);
    host_u.send(1, 0, 1, 8'h08);
    host_u.send(1, 0, 1, 8'hEC);
    repeat (6) @(posedge aclk);
    `CHK(host_u.sig_cnt, 8'h02)
    `CHK(host_u.unsup_cnt, 8'h01)
    `CHK(port_en, 15'h00F0)
    host_u.send(1, 1, 0, 8'h00);
    host_u.comreset();
    settle();
    `CHK(port_en, 15'h0001)
    rdchk(`PMRS_OFF_STATUS, 32'hE);
    rdchk(`PMRS_OFF_CTRL, 32'h0);
    rdchk(`PMRS_OFF_PORTEN, 32'h0);
    host_u.send(1, 0, 0, 8'h00);
    repeat (6) @(posedge aclk);
    `CHK(host_u.sig_cnt, 8'h02)
    finish_test();
  end
endmodule // testbench
